/* File: alc_pkg.sv */
// Purpose: shared constants for the alarm low-limit and command echo register logic
// Assumes: 16-bit serial frames, address in bits 15:9, write flag in bit 8, data in bits 7:0
// Notes: link bit counts are rising-edge counts since chip select went low
package alc_pkg;
    localparam int CMD_W = 16;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int NUM_CH_DEF = 8;
    localparam int CH_STRIDE = 5;
    localparam logic [ADDR_W-1:0] ADDR_LOW_MSB_CH0 = 7'h18;
    localparam logic [ADDR_W-1:0] ADDR_LOW_LSB_CH0 = 7'h19;
    localparam logic [ADDR_W-1:0] ADDR_ECHO = 7'h3F;
    localparam logic [DATA_W-1:0] LIMIT_RESET = 8'h00;
    localparam logic [DATA_W-1:0] ECHO_RESET = 8'h00;
    localparam logic [4:0] BIT_ADDR_LAST = 5'h07;
    localparam logic [4:0] BIT_CMD_LAST = 5'h0F;
    localparam logic [4:0] BIT_SDO_START = 5'h10;
    localparam logic [4:0] BIT_SDO_ZERO = 5'h18;
    localparam logic [4:0] BIT_CNT_MAX = 5'h1F;
endpackage

/* File: alc_limit_mem.sv */
// Purpose: small byte memory holding the low alarm limit bytes
// Assumes: one write port, one registered read port, all on the system clock
// Notes: every word is also brought out flat so the limits can feed comparators
`timescale 1ns/100ps
`default_nettype none
module alc_limit_mem #(
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [alc_pkg::DATA_W-1:0] wdata_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [alc_pkg::DATA_W-1:0] rdata_o,
    output logic [DEPTH*alc_pkg::DATA_W-1:0] flat_o
);
    import alc_pkg::*;

    logic [DATA_W-1:0] mem_reg [DEPTH];

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= LIMIT_RESET;
            end
        end else if (we_i) begin
            mem_reg[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rdata_o <= LIMIT_RESET;
        end else begin
            rdata_o <= mem_reg[raddr_i];
        end
    end

    for (genvar g = 0; g < DEPTH; g++) begin : g_flat
        assign flat_o[g*DATA_W +: DATA_W] = mem_reg[g];
    end
endmodule
`default_nettype wire

/* File: alc_alarm_regs.sv */
// Purpose: low alarm limit registers and command echo behind the serial link
// Assumes: link clock idles low, data sampled on rising edges, output changes on falling edges
// Notes: read data crosses as a quasi-static word, settled long before the 16th falling edge
`timescale 1ns/100ps
`default_nettype none
module alc_alarm_regs #(
    parameter int NUM_CH = alc_pkg::NUM_CH_DEF
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic link_sclk_i,
    input wire logic link_cs_n_i,
    input wire logic link_sdi_i,
    output logic serial_data_out_o,
    output logic [NUM_CH*16-1:0] chan_low_alarm_limit_o,
    output logic [alc_pkg::DATA_W-1:0] last_command_echo_o
);
    import alc_pkg::*;

    localparam int DEPTH = 2 * NUM_CH;
    localparam int IDX_W = $clog2(DEPTH);

    // {hit, byte index}; even index is the upper byte of a channel
    function automatic logic [IDX_W:0] lim_decode(input logic [ADDR_W-1:0] a);
        logic [IDX_W:0] r;
        r = '0;
        for (int ch = 0; ch < NUM_CH; ch++) begin
            if (a == ADDR_LOW_MSB_CH0 + ADDR_W'(ch * CH_STRIDE)) begin
                r = {1'b1, IDX_W'(2 * ch)};
            end else if (a == ADDR_LOW_LSB_CH0 + ADDR_W'(ch * CH_STRIDE)) begin
                r = {1'b1, IDX_W'(2 * ch + 1)};
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // link domain

    logic [4:0] bit_cnt_reg;
    logic [4:0] bit_cnt_next;
    logic [CMD_W-1:0] shift_reg;
    logic [CMD_W-1:0] shift_next;
    logic [ADDR_W-1:0] addr_hold_reg;
    logic [CMD_W-1:0] cmd_hold_reg;
    logic rd_tgl_reg;
    logic done_tgl_reg;
    logic [DATA_W-1:0] sdo_shift_reg;
    logic [DATA_W-1:0] rdata_reg;

    assign shift_next = {shift_reg[CMD_W-2:0], link_sdi_i};
    assign bit_cnt_next = (bit_cnt_reg == BIT_CNT_MAX) ? bit_cnt_reg : bit_cnt_reg + 5'h01;

    // chip select clears the frame state; the clock may stop between frames
    always_ff @(posedge link_sclk_i or posedge link_cs_n_i) begin
        if (link_cs_n_i) begin
            bit_cnt_reg <= '0;
            shift_reg <= '0;
        end else begin
            bit_cnt_reg <= bit_cnt_next;
            shift_reg <= shift_next;
        end
    end

    // toggles survive chip select so no event is lost between frames
    always_ff @(posedge link_sclk_i or posedge rst_i) begin
        if (rst_i) begin
            addr_hold_reg <= '0;
            cmd_hold_reg <= '0;
            rd_tgl_reg <= 1'b0;
            done_tgl_reg <= 1'b0;
        end else begin
            if (bit_cnt_reg == BIT_ADDR_LAST) begin
                addr_hold_reg <= shift_reg[ADDR_W-1:0];
                rd_tgl_reg <= ~rd_tgl_reg;
            end
            if (bit_cnt_reg == BIT_CMD_LAST) begin
                cmd_hold_reg <= shift_next;
                done_tgl_reg <= ~done_tgl_reg;
            end
        end
    end

    // zeros refill from below, so bits after the echo byte are zero
    always_ff @(negedge link_sclk_i or posedge link_cs_n_i) begin
        if (link_cs_n_i) begin
            sdo_shift_reg <= '0;
        end else if (bit_cnt_reg == BIT_SDO_START) begin
            sdo_shift_reg <= rdata_reg;
        end else begin
            sdo_shift_reg <= {sdo_shift_reg[DATA_W-2:0], 1'b0};
        end
    end

    assign serial_data_out_o = sdo_shift_reg[DATA_W-1];

    ////////////////////////////////////////////////////////////////////////////////
    // system domain

    logic [2:0] done_sync_reg;
    logic [2:0] rd_sync_reg;
    logic done_pulse;
    logic rd_pulse;
    logic [ADDR_W-1:0] cmd_addr;
    logic cmd_wr;
    logic [IDX_W:0] wr_dec;
    logic [IDX_W:0] rd_dec;
    logic mem_we;
    logic [DATA_W-1:0] cmd_echo_w;
    logic [DATA_W-1:0] last_cmd_reg;
    logic [DATA_W-1:0] last_cmd_next;
    logic rd_pend_reg;
    logic rd_hit_reg;
    logic rd_echo_reg;
    logic [DATA_W-1:0] rdata_next;
    logic [DATA_W-1:0] mem_rdata;
    logic [DEPTH*DATA_W-1:0] mem_flat;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            done_sync_reg <= '0;
            rd_sync_reg <= '0;
        end else begin
            done_sync_reg <= {done_sync_reg[1:0], done_tgl_reg};
            rd_sync_reg <= {rd_sync_reg[1:0], rd_tgl_reg};
        end
    end

    // held words are stable for many link cycles after each toggle
    assign done_pulse = done_sync_reg[2] ^ done_sync_reg[1];
    assign rd_pulse = rd_sync_reg[2] ^ rd_sync_reg[1];
    assign cmd_addr = cmd_hold_reg[CMD_W-1:CMD_W-ADDR_W];
    assign cmd_wr = cmd_hold_reg[DATA_W];
    assign cmd_echo_w = cmd_hold_reg[CMD_W-1:DATA_W];
    assign wr_dec = lim_decode(cmd_addr);
    assign rd_dec = lim_decode(addr_hold_reg);
    assign mem_we = done_pulse & cmd_wr & wr_dec[IDX_W];
    assign last_cmd_next = done_pulse ? cmd_echo_w : last_cmd_reg;
    assign rdata_next = rd_echo_reg ? last_cmd_reg : (rd_hit_reg ? mem_rdata : '0);

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            last_cmd_reg <= ECHO_RESET;
            rd_pend_reg <= 1'b0;
            rd_hit_reg <= 1'b0;
            rd_echo_reg <= 1'b0;
            rdata_reg <= '0;
        end else begin
            last_cmd_reg <= last_cmd_next;
            rd_pend_reg <= rd_pulse;
            if (rd_pulse) begin
                rd_hit_reg <= rd_dec[IDX_W];
                rd_echo_reg <= (addr_hold_reg == ADDR_ECHO);
            end
            if (rd_pend_reg) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    alc_limit_mem #(
        .DEPTH(DEPTH),
        .AW(IDX_W)
    ) u_mem (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .we_i(mem_we),
        .waddr_i(wr_dec[IDX_W-1:0]),
        .wdata_i(cmd_hold_reg[DATA_W-1:0]),
        .raddr_i(rd_dec[IDX_W-1:0]),
        .rdata_o(mem_rdata),
        .flat_o(mem_flat)
    );

    // upper byte at the even index, lower byte at the odd one
    for (genvar c = 0; c < NUM_CH; c++) begin : g_limit
        assign chan_low_alarm_limit_o[c*16 +: 16] = {mem_flat[2*c*DATA_W +: DATA_W],
                                                     mem_flat[(2*c+1)*DATA_W +: DATA_W]};
    end

    assign last_command_echo_o = last_cmd_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    logic [DATA_W-1:0] ch0_msb_w;
    logic [DATA_W-1:0] ch0_lsb_w;
    logic [DATA_W-1:0] wdata_w;
    logic rdata_msb_w;

    assign ch0_msb_w = chan_low_alarm_limit_o[15:8];
    assign ch0_lsb_w = chan_low_alarm_limit_o[7:0];
    assign wdata_w = cmd_hold_reg[DATA_W-1:0];
    assign rdata_msb_w = rdata_reg[DATA_W-1];

    a_reset_clears_limit: assert property (@(posedge clk_sys_i) rst_i |=> chan_low_alarm_limit_o == '0)
        else $error("low limits not cleared by reset");
    a_reset_clears_echo: assert property (@(posedge clk_sys_i) rst_i |=> last_cmd_reg == ECHO_RESET)
        else $error("echo not cleared by reset");
    a_echo_takes_cmd: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        done_pulse |=> last_cmd_reg == $past(cmd_echo_w))
        else $error("echo does not hold last command upper byte");
    a_echo_holds_value: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !done_pulse |=> $stable(last_cmd_reg))
        else $error("echo changed without a finished frame");
    a_echo_not_written: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        done_pulse && cmd_addr == ADDR_ECHO |-> !mem_we)
        else $error("write to echo location reached memory");
    a_limit_lsb_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        mem_we && cmd_addr == ADDR_LOW_LSB_CH0 |=> ch0_lsb_w == $past(wdata_w) && $stable(ch0_msb_w))
        else $error("channel zero lower byte write wrong");
    a_limit_msb_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        mem_we && cmd_addr == ADDR_LOW_MSB_CH0 |=> ch0_msb_w == $past(wdata_w) && $stable(ch0_lsb_w))
        else $error("channel zero upper byte write wrong");
    a_readback_echo: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        rd_pulse && addr_hold_reg == ADDR_ECHO |=> ##1 rdata_reg == $past(last_cmd_reg))
        else $error("echo read data wrong");
    a_sdo_first_bit: assert property (@(negedge link_sclk_i) disable iff (link_cs_n_i)
        bit_cnt_reg == BIT_SDO_START |=> serial_data_out_o == rdata_msb_w)
        else $error("read-back msb not out at 16th falling edge");
    a_sdo_tail_zero: assert property (@(negedge link_sclk_i) disable iff (link_cs_n_i)
        bit_cnt_reg >= BIT_SDO_ZERO |=> !serial_data_out_o)
        else $error("bits after the echo byte not zero");

    c_limit_write: cover property (@(posedge clk_sys_i) disable iff (rst_i) mem_we);
    c_echo_read: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        rd_pulse && addr_hold_reg == ADDR_ECHO);
    c_frame_tail: cover property (@(negedge link_sclk_i) disable iff (link_cs_n_i)
        bit_cnt_reg == BIT_SDO_ZERO);
endmodule
`default_nettype wire

/* File: alc_host_model.sv */
// Purpose: host-side serial master sending command frames to the register logic
// Assumes: link clock idles low, period 64 ns, stands still between frames
// Notes: data line shows the inverse of its last bit once a frame ends
`timescale 1ns/100ps
`default_nettype none
module alc_host_model (
    output logic link_sclk_o,
    output logic link_cs_n_o,
    output logic link_sdi_o,
    input wire logic serial_data_out_i
);
    initial begin
        link_sclk_o = 1'b0;
        link_cs_n_o = 1'b1;
        link_sdi_o = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // rx gathers the output from rise 17 on, plus one sample after the last fall
    task automatic frame(input logic [15:0] cmd, input int nclk, output logic [16:0] rx);
        rx = '0;
        #5 link_cs_n_o = 1'b0;
        for (int k = 1; k <= nclk; k++) begin
            link_sdi_o = (k <= 16) ? cmd[16-k] : 1'b0;
            #32 link_sclk_o = 1'b1;
            if (k > 16) rx = {rx[15:0], serial_data_out_i};
            #32 link_sclk_o = 1'b0;
        end
        #16 rx = {rx[15:0], serial_data_out_i};
        // nothing useful follows bit 24, so the frame may stop there
        link_cs_n_o = 1'b1;
        link_sdi_o = ~link_sdi_o;
        #200;
    endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
// Purpose: self-checking bench for the low-limit and command echo registers
// Assumes: frames are launched through the host model, one at a time
// Notes: the 200 ns gap after each frame covers the crossing into the system clock
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import alc_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    wire logic sclk, cs_n, sdi, serial_data_out;
    wire logic [NUM_CH_DEF*16-1:0] limits;
    wire logic [DATA_W-1:0] echo;
    int error_cnt = 0;
    int total_checks = 0;
    int c;
    logic [16:0] rx;
    logic [7:0] hi, lo, last, e;
    logic [ADDR_W-1:0] a;
    always #2.5 clk_sys_i = ~clk_sys_i;
    alc_alarm_regs #(.NUM_CH(NUM_CH_DEF)) u_alc_alarm_regs (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .link_sclk_i(sclk),
        .link_cs_n_i(cs_n),
        .link_sdi_i(sdi),
        .serial_data_out_o(serial_data_out),
        .chan_low_alarm_limit_o(limits),
        .last_command_echo_o(echo)
    );
    alc_host_model u_alc_host_model (
        .link_sclk_o(sclk),
        .link_cs_n_o(cs_n),
        .link_sdi_o(sdi),
        .serial_data_out_i(serial_data_out)
    );
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] mk(input logic [ADDR_W-1:0] ad, input logic wr, input logic [7:0] d);
        return {ad, wr, d};
    endfunction
    task automatic chk(input logic [16:0] got, input logic [16:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // frames shorter than 16 clocks never count as executed
    task automatic send(input logic [15:0] cm, input int n);
        u_alc_host_model.frame(cm, n, rx);
        if (n >= 16) last = cm[15:8];
    endtask
    task automatic rd_echo();
        e = last;
        send(mk(ADDR_ECHO, 1'b0, 8'h00), 32);
        chk(rx, {e, 9'h000}, "echo read");
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #300_000;
        error_cnt++;
        end_sim();
    end
    initial begin
        void'($urandom(32'h20b4_f5ba));
        last = 8'h00;
        repeat (20) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        for (c = 0; c < NUM_CH_DEF; c++) begin
            chk({1'b0, limits[c*16+:16]}, {1'b0, LIMIT_RESET, LIMIT_RESET}, "limit reset");
        end
        chk({9'h000, echo}, {9'h000, ECHO_RESET}, "echo reset");
        rd_echo();
        for (int i = 0; i < 6; i++) begin
            c = (i == 0) ? 0 : ((i == 5) ? NUM_CH_DEF - 1 : $urandom_range(NUM_CH_DEF - 1));
            hi = 8'($urandom);
            lo = 8'($urandom);
            a = ADDR_LOW_MSB_CH0 + ADDR_W'(CH_STRIDE * c);
            send(mk(a, 1'b1, hi), 24);
            send(mk(a + 7'h01, 1'b1, lo), 24);
            chk({1'b0, limits[c*16+:16]}, {1'b0, hi, lo}, "limit pair");
            chk({9'h000, echo}, {9'h000, last}, "echo upper byte");
            send(mk(a + 7'h01, 1'b0, 8'h00), 24);
            chk(rx, {8'h00, lo, 1'b0}, "limit read");
            send(mk(a, 1'b0, 8'h00), 24);
            chk(rx, {8'h00, hi, 1'b0}, "limit msb read");
            rd_echo();
        end
        // address between channel pairs reads back as zero
        send(mk(7'h20, 1'b0, 8'h00), 24);
        chk(rx, 17'h0_0000, "unmapped read");
        // a write aimed at the echo must not land its data
        send(mk(ADDR_ECHO, 1'b1, 8'hA5), 24);
        chk({9'h000, echo}, {9'h000, 8'h7F}, "echo write");
        rd_echo();
        send(mk(ADDR_LOW_LSB_CH0, 1'b1, 8'h5A), 24);
        send(mk(ADDR_LOW_LSB_CH0, 1'b1, 8'h11), 10);
        chk({9'h000, echo}, {9'h000, last}, "cut frame");
        chk({9'h000, limits[7:0]}, {9'h000, 8'h5A}, "cut frame write");
        rd_echo();
        end_sim();
    end
endmodule
`default_nettype wire
